// ===== gdp_map.vh
// Register map and reset values for the GPIO data and direction ports
`ifndef GDP_MAP_VH
`define GDP_MAP_VH
`define GDP_ADDR_W 16
`define GDP_P0_LEVEL 16'h5200
`define GDP_P0_DRIVE 16'h5201
`define GDP_P0_DIR 16'h5202
`define GDP_P1_LEVEL 16'h5210
`define GDP_P1_DRIVE 16'h5211
`define GDP_P1_DIR 16'h5212
`define GDP_P2_LEVEL 16'h5220
`define GDP_P2_DRIVE 16'h5221
`define GDP_P2_DIR 16'h5222
`define GDP_P3_LEVEL 16'h5230
`define GDP_P3_DRIVE 16'h5231
`define GDP_P3_DIR 16'h5232
`define GDP_FSEL 16'h52f0
`define GDP_DRIVE_RST 8'h00
`define GDP_DIR_RST 8'h00
`define GDP_FSEL_RST 8'h00
`endif

// ===== gdp_port_bits.v
// One GPIO port: sync, drive and direction registers, pin control
`timescale 1ns/100ps
`default_nettype none
`include "gdp_map.vh"
module gdp_port_bits #(
    parameter W = 8
) (
    input wire core_clk,
    input wire nrst,
    input wire [W-1:0] pinIn,
    input wire driveWr,
    input wire dirWr,
    input wire [W-1:0] wrData,
    input wire periphSel,
    input wire [W-1:0] periphOe,
    input wire [W-1:0] periphOut,
    output wire [W-1:0] pinOut,
    output wire [W-1:0] pinOe,
    output wire [W-1:0] levelBits,
    output wire [W-1:0] driveBits,
    output wire [W-1:0] dirBits
);
    reg [W-1:0] syncA_q;
    reg [W-1:0] syncB_q;
    reg [W-1:0] drive_q;
    reg [W-1:0] dir_q;
    // Reset values are byte wide; the narrow port keeps only its low bits
    localparam [7:0] DRIVE_RST = `GDP_DRIVE_RST;
    localparam [7:0] DIR_RST = `GDP_DIR_RST;
    // ----------------------------------------
    // Synchroniser and registers
    // ----------------------------------------
    always @(posedge core_clk) begin
        syncA_q <= pinIn;
        syncB_q <= syncA_q;
        if (!nrst) begin
            drive_q <= DRIVE_RST[W-1:0];
            dir_q <= DIR_RST[W-1:0];
        end else begin
            if (driveWr) begin
                drive_q <= wrData;
            end
            if (dirWr) begin
                dir_q <= wrData;
            end
        end
    end
    // Output mode reads the own driven level; value is not guaranteed
    assign levelBits = syncB_q;
    assign driveBits = drive_q;
    assign dirBits = dir_q;
    assign pinOe = periphSel ? periphOe : dir_q;
    assign pinOut = periphSel ? periphOut : drive_q;
endmodule // gdp_port_bits
`default_nettype wire

// ===== gdp_ports.v
// Register slave and four GPIO ports with data and direction control
//
// Notes on behaviour
// - Input-mode pin high reads 1, low reads 0; bit n is pin n.
// - Level bits of output-mode pins are undefined.
// - Level registers are read-only; writes change nothing.
// - Fourth port has four bits; upper four read zero.
// - Stored drive bit 1 drives pin high, 0 drives low.
// - Drive bits reset to 0.
// - Drive register written in input mode keeps value for later.
// - Direction bit 1 is output, 0 is input.
// - Direction bits reset to 0, all pins input.
// - Peripheral function sets direction instead of direction bit.
// - Every register is eight bits, one byte per address; port 3 drive and direction store only four bits.
//
// Implementation choice: strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "gdp_map.vh"
module gdp_ports #(
    parameter WIDE = 8,
    parameter NARROW = 4
) (
    input wire core_clk,
    input wire nrst,
    input wire [`GDP_ADDR_W-1:0] regAddr,
    input wire [7:0] regWdata,
    input wire regWr,
    input wire regRd,
    output reg [7:0] regRdata,
    input wire [WIDE-1:0] port0PinIn,
    output wire [WIDE-1:0] port0PinOut,
    output wire [WIDE-1:0] port0PinOe,
    input wire [WIDE-1:0] port0PeriphOe,
    input wire [WIDE-1:0] port0PeriphOut,
    input wire [WIDE-1:0] port1PinIn,
    output wire [WIDE-1:0] port1PinOut,
    output wire [WIDE-1:0] port1PinOe,
    input wire [WIDE-1:0] port1PeriphOe,
    input wire [WIDE-1:0] port1PeriphOut,
    input wire [WIDE-1:0] port2PinIn,
    output wire [WIDE-1:0] port2PinOut,
    output wire [WIDE-1:0] port2PinOe,
    input wire [WIDE-1:0] port2PeriphOe,
    input wire [WIDE-1:0] port2PeriphOut,
    input wire [NARROW-1:0] port3PinIn,
    output wire [NARROW-1:0] port3PinOut,
    output wire [NARROW-1:0] port3PinOe,
    input wire [NARROW-1:0] port3PeriphOe,
    input wire [NARROW-1:0] port3PeriphOut,
    output wire [3:0] funcSel
);
    reg [7:0] fsel_q;
    reg [7:0] rdata_d;
    wire [WIDE-1:0] lvl0, drv0, dir0, lvl1, drv1, dir1, lvl2, drv2, dir2;
    wire [NARROW-1:0] lvl3, drv3, dir3;
    // ----------------------------------------
    // Function select, one bit per port
    // ----------------------------------------
    always @(posedge core_clk) begin
        if (!nrst) begin
            fsel_q <= `GDP_FSEL_RST;
        end else if (regWr && regAddr == `GDP_FSEL) begin
            fsel_q <= {4'h0, regWdata[3:0]};
        end
    end
    assign funcSel = fsel_q[3:0];
    // ----------------------------------------
    // Ports; level addresses have no write decode
    // ----------------------------------------
    gdp_port_bits #(.W(WIDE)) uPort0 (
        .core_clk(core_clk), .nrst(nrst), .pinIn(port0PinIn),
        .driveWr(regWr && regAddr == `GDP_P0_DRIVE),
        .dirWr(regWr && regAddr == `GDP_P0_DIR), .wrData(regWdata[WIDE-1:0]),
        .periphSel(fsel_q[0]), .periphOe(port0PeriphOe), .periphOut(port0PeriphOut),
        .pinOut(port0PinOut), .pinOe(port0PinOe),
        .levelBits(lvl0), .driveBits(drv0), .dirBits(dir0)
    );
    gdp_port_bits #(.W(WIDE)) uPort1 (
        .core_clk(core_clk), .nrst(nrst), .pinIn(port1PinIn),
        .driveWr(regWr && regAddr == `GDP_P1_DRIVE),
        .dirWr(regWr && regAddr == `GDP_P1_DIR), .wrData(regWdata[WIDE-1:0]),
        .periphSel(fsel_q[1]), .periphOe(port1PeriphOe), .periphOut(port1PeriphOut),
        .pinOut(port1PinOut), .pinOe(port1PinOe),
        .levelBits(lvl1), .driveBits(drv1), .dirBits(dir1)
    );
    gdp_port_bits #(.W(WIDE)) uPort2 (
        .core_clk(core_clk), .nrst(nrst), .pinIn(port2PinIn),
        .driveWr(regWr && regAddr == `GDP_P2_DRIVE),
        .dirWr(regWr && regAddr == `GDP_P2_DIR), .wrData(regWdata[WIDE-1:0]),
        .periphSel(fsel_q[2]), .periphOe(port2PeriphOe), .periphOut(port2PeriphOut),
        .pinOut(port2PinOut), .pinOe(port2PinOe),
        .levelBits(lvl2), .driveBits(drv2), .dirBits(dir2)
    );
    // Narrow port stores only four bits, so reserved writes vanish
    gdp_port_bits #(.W(NARROW)) uPort3 (
        .core_clk(core_clk), .nrst(nrst), .pinIn(port3PinIn),
        .driveWr(regWr && regAddr == `GDP_P3_DRIVE),
        .dirWr(regWr && regAddr == `GDP_P3_DIR), .wrData(regWdata[NARROW-1:0]),
        .periphSel(fsel_q[3]), .periphOe(port3PeriphOe), .periphOut(port3PeriphOut),
        .pinOut(port3PinOut), .pinOe(port3PinOe),
        .levelBits(lvl3), .driveBits(drv3), .dirBits(dir3)
    );
    // ----------------------------------------
    // Read mux, data registered one cycle after strobe
    // ----------------------------------------
    always @* begin
        rdata_d = 8'h00;
        case (regAddr)
            `GDP_P0_LEVEL: rdata_d = lvl0;
            `GDP_P0_DRIVE: rdata_d = drv0;
            `GDP_P0_DIR: rdata_d = dir0;
            `GDP_P1_LEVEL: rdata_d = lvl1;
            `GDP_P1_DRIVE: rdata_d = drv1;
            `GDP_P1_DIR: rdata_d = dir1;
            `GDP_P2_LEVEL: rdata_d = lvl2;
            `GDP_P2_DRIVE: rdata_d = drv2;
            `GDP_P2_DIR: rdata_d = dir2;
            `GDP_P3_LEVEL: rdata_d = {4'h0, lvl3};
            `GDP_P3_DRIVE: rdata_d = {4'h0, drv3};
            `GDP_P3_DIR: rdata_d = {4'h0, dir3};
            `GDP_FSEL: rdata_d = fsel_q;
            default: rdata_d = 8'h00;
        endcase
    end
    always @(posedge core_clk) begin
        if (!nrst) begin
            regRdata <= 8'h00;
        end else if (regRd) begin
            regRdata <= rdata_d;
        end else begin
            regRdata <= 8'h00;
        end
    end
endmodule // gdp_ports
`default_nettype wire

// ===== gdp_checker.sv
// Concurrent checks on the GPIO port register bus and pin controls
`timescale 1ns/100ps
`default_nettype none
`include "gdp_map.vh"
module gdp_checker (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [15:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regRdata,
    input wire logic [7:0] port0PinIn,
    input wire logic [7:0] port0PinOut,
    input wire logic [7:0] port0PinOe,
    input wire logic [7:0] port0PeriphOe,
    input wire logic [3:0] port3PinOe,
    input wire logic [3:0] funcSel
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    a_rdata_idle: assert property (!regRd |=> regRdata == 8'h00)
        else $error("read data not idle");
    a_reset_clear: assert property (disable iff (1'b0) !nrst |=>
        port0PinOe == 8'h00 && port0PinOut == 8'h00 && funcSel == 4'h0) else $error("reset");
    a_dir_write: assert property (regWr && regAddr == `GDP_P0_DIR && !funcSel[0]
        |=> port0PinOe == $past(regWdata)) else $error("direction");
    a_drive_write: assert property (regWr && regAddr == `GDP_P0_DRIVE && !funcSel[0]
        |=> port0PinOut == $past(regWdata)) else $error("drive value");
    a_narrow_dir: assert property (regWr && regAddr == `GDP_P3_DIR && !funcSel[3]
        |=> port3PinOe == $past(regWdata[3:0])) else $error("narrow port");
    a_level_ro: assert property (regWr && regAddr == `GDP_P0_LEVEL
        |=> $stable(port0PinOe) && $stable(port0PinOut)) else $error("level write");
    a_sync_level: assert property (regRd && regAddr == `GDP_P0_LEVEL
        |=> regRdata == $past(port0PinIn, 3)) else $error("level read");
    a_periph_dir: assert property (funcSel[0] |-> port0PinOe == port0PeriphOe)
        else $error("peripheral direction");
endmodule // gdp_checker
bind gdp_ports gdp_checker chk(.core_clk, .nrst, .regAddr, .regWdata, .regWr, .regRd,
    .regRdata, .port0PinIn, .port0PinOut, .port0PinOe, .port0PeriphOe, .port3PinOe, .funcSel);
`default_nettype wire

// ===== gdp_pin_model.sv
// Far-side pin model: external drivers seen through the port pads
`timescale 1ns/100ps
`default_nettype none
module gdp_pin_model #(
    parameter W = 8
) (
    input wire logic [W-1:0] oe,
    input wire logic [W-1:0] out,
    input wire logic [W-1:0] ext,
    output logic [W-1:0] pin
);
    // Port driver wins where enabled; elsewhere the outside device drives
    assign pin = (oe & out) | (~oe & ext);
endmodule // gdp_pin_model
`default_nettype wire

// ===== tb_gpio_data_direction_ports.sv
// Self-checking bench for the GPIO data and direction ports
`timescale 1ns/100ps
`default_nettype none
`include "gdp_map.vh"
module tb_gpio_data_direction_ports;
    logic core_clk = 0, nrst = 0, regWr = 0, regRd = 0;
    logic [15:0] regAddr = 0;
    logic [7:0] regWdata = 0, d, m, exp;
    logic [7:0] ext[4] = '{4{8'h00}}, pe[4] = '{4{8'h00}}, pv[4] = '{4{8'h00}};
    wire [7:0] regRdata, oe[4], po[4], pin[4];
    wire [3:0] funcSel;
    int n_errors = 0, total_checks = 0, seed = 49, drv[4], dir[4], p, k;
    always #25 core_clk = ~core_clk;
    // Narrow port leaves the upper pad bits unused; hold them quiet
    assign oe[3][7:4] = 4'h0;
    assign po[3][7:4] = 4'h0;
    gdp_ports DUT(.core_clk, .nrst, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
        .port0PinIn(pin[0]), .port0PinOut(po[0]), .port0PinOe(oe[0]),
        .port0PeriphOe(pe[0]), .port0PeriphOut(pv[0]), .port1PinIn(pin[1]),
        .port1PinOut(po[1]), .port1PinOe(oe[1]), .port1PeriphOe(pe[1]),
        .port1PeriphOut(pv[1]), .port2PinIn(pin[2]), .port2PinOut(po[2]),
        .port2PinOe(oe[2]), .port2PeriphOe(pe[2]), .port2PeriphOut(pv[2]),
        .port3PinIn(pin[3][3:0]), .port3PinOut(po[3][3:0]), .port3PinOe(oe[3][3:0]),
        .port3PeriphOe(pe[3][3:0]), .port3PeriphOut(pv[3][3:0]), .funcSel);
    for (genvar g = 0; g < 4; g = g + 1) begin : pm
        gdp_pin_model u(.oe(oe[g]), .out(po[g]), .ext(ext[g]), .pin(pin[g]));
    end
    function automatic logic [7:0] mk(int q);
        return q == 3 ? 8'h0f : 8'hff;
    endfunction
    task chk(input logic [7:0] s, input logic [7:0] e);
        total_checks++;
        if (s !== e) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // Called just after an edge; returns just after the edge that takes it
    task bus(input logic w, input logic r, input logic [15:0] a, input logic [7:0] v);
        regWr <= w;
        regRd <= r;
        regAddr <= a;
        regWdata <= v;
        @(posedge core_clk);
        #1;
    endtask
    task end_of_test;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        #100000;
        n_errors++;
        end_of_test;
    end
    initial begin
        repeat (8) @(posedge core_clk);
        #1;
        nrst <= 1;
        repeat (150) begin
            p = $unsigned($random(seed)) % 4;
            k = $unsigned($random(seed)) % 4;
            d = $random(seed);
            m = mk(p);
            // Two idle edges let the new pin level clear the synchroniser
            if (k == 0) begin
                ext[p] <= $random(seed);
                bus(0, 0, 0, 0);
                bus(0, 0, 0, 0);
            end
            bus(1, 0, `GDP_P0_LEVEL + 16 * p + k, d & m);
            if (k == 1) drv[p] = d & m;
            if (k == 2) dir[p] = d & m;
            bus(0, 1, `GDP_P0_LEVEL + 16 * p + k, 0);
            exp = k == 0 ? ext[p] & m & ~dir[p] : k == 1 ? drv[p] : k == 2 ? dir[p] : 0;
            chk(k == 0 ? regRdata & ~dir[p] : regRdata, exp);
            chk(oe[p] & m, dir[p]);
            chk(po[p] & m, drv[p]);
        end
        for (p = 0; p < 4; p++) begin
            pe[p] <= $random(seed);
            pv[p] <= $random(seed);
        end
        bus(1, 0, `GDP_FSEL, 8'h0f);
        chk(funcSel, 8'h0f);
        for (p = 0; p < 4; p++) begin
            chk(oe[p] & mk(p), pe[p] & mk(p));
            chk(po[p] & mk(p), pv[p] & mk(p));
        end
        bus(0, 1, `GDP_FSEL, 0);
        chk(regRdata, 8'h0f);
        bus(1, 0, `GDP_FSEL, 8'h00);
        chk(funcSel, 8'h00);
        for (p = 0; p < 4; p++) begin
            chk(oe[p] & mk(p), dir[p]);
            chk(po[p] & mk(p), drv[p]);
        end
        // Mid-run reset must clear drive and direction written above
        nrst <= 0;
        bus(0, 0, 0, 0);
        bus(0, 0, 0, 0);
        nrst <= 1;
        for (p = 0; p < 4; p++) begin
            drv[p] = 0;
            dir[p] = 0;
            bus(0, 1, `GDP_P0_DRIVE + 16 * p, 0);
            chk(regRdata, drv[p]);
            bus(0, 1, `GDP_P0_DIR + 16 * p, 0);
            chk(regRdata, dir[p]);
            chk(oe[p] & mk(p), dir[p]);
            chk(po[p] & mk(p), drv[p]);
        end
        bus(0, 0, 0, 0);
        end_of_test;
    end
endmodule // tb_gpio_data_direction_ports
`default_nettype wire
